// ### verilog/ist_pkg.sv
package ist_pkg;

	// Cycle type indices, in sequencing order
	localparam logic [2:0] IST_CYC_FETCH = 3'h0;
	localparam logic [2:0] IST_CYC_BRADR = 3'h1;
	localparam logic [2:0] IST_CYC_STACK = 3'h2;
	localparam logic [2:0] IST_CYC_BYTE  = 3'h3;
	localparam logic [2:0] IST_CYC_WORD  = 3'h4;
	localparam logic [2:0] IST_CYC_INTOP = 3'h5;
	localparam logic [2:0] IST_CYC_NONE  = 3'h6;

	// States per cycle
	localparam logic [1:0] IST_ST_MEM       = 2'h2;
	localparam logic [1:0] IST_ST_INTOP     = 2'h1;
	localparam logic [1:0] IST_ST_PERI_FAST = 2'h2;
	localparam logic [1:0] IST_ST_PERI_SLOW = 2'h3;

	localparam int        IST_CNT_W   = 4;
	localparam int        IST_TOT_W   = 9;
	localparam logic [3:0] IST_CNT_ZERO = 4'h0;
	localparam logic [3:0] IST_CNT_ONE  = 4'h1;
	localparam logic [3:0] IST_CNT_TWO  = 4'h2;

	// Counts per cycle type, index 0 = fetch ... 5 = internal operation
	typedef logic [5:0][IST_CNT_W-1:0] ist_cnt_t;

	typedef enum logic [2:0] {
		IST_CLS_CUSTOM   = 3'h0,
		IST_CLS_REG_ALU  = 3'h1,
		IST_CLS_BRANCH8  = 3'h2,
		IST_CLS_BIT_SET  = 3'h3,
		IST_CLS_BIT_CLR  = 3'h4,
		IST_CLS_BIT_AND  = 3'h5,
		IST_CLS_SUBR_IND = 3'h6
	} ist_class_e;

	typedef enum logic [2:0] {
		IST_S_IDLE = 3'b001,
		IST_S_RUN  = 3'b010,
		IST_S_DONE = 3'b100
	} ist_state_e;

	typedef struct packed {
		ist_class_e cls;
		ist_cnt_t   cnt;
		logic       periph;
		logic       slow;
	} ist_req_s;

endpackage

// ### verilog/ist_timing.sv
`timescale 1ns/1ps
// Contract
// RULE_01 - Each instruction takes the sum over six cycle types of count times per-cycle cost.
// RULE_02 - On-chip memory fetch, branch read, stack, byte and word cycles take 2 states, internal ops 1.
// RULE_03 - A data access to a peripheral module takes 2 or 3 states, fixed by the module addressed.
// RULE_04 - Bit set on an absolute memory operand is 2 fetches and 2 byte accesses, 8 states on-chip.
// RULE_05 - Memory-indirect subroutine jump is 2 fetches, 1 branch read and 1 stack op, 8 states.
// RULE_06 - Register ALU uses 1 fetch, 8-bit branch 2, bit AND 2 plus 1 byte, bit clear 2 plus 2.
module ist_timing
(
	input  wire logic              CLK,
	input  wire logic              RST_N,
	input  wire logic              START,
	input  wire ist_pkg::ist_req_s REQ,
	output logic                   BUSY,
	output logic                   DONE,
	output logic                   CYC_STROBE,
	output logic [2:0]             CYC_TYPE,
	output logic [8:0]             TOTAL_STATES
);
	import ist_pkg::*;

	ist_state_e                  state_r;
	ist_cnt_t                    cnt_r;
	ist_cnt_t                    cnt_dec;
	ist_cnt_t                    req_cnt;
	logic [2:0]                  idx_r;
	logic [2:0]                  idx_nxt;
	logic [2:0]                  idx_first;
	logic [1:0]                  st_r;
	logic                        periph_r;
	logic                        slow_r;
	logic [IST_TOT_W-1:0]        exp_r;
	logic [1:0]                  len_r;
	logic                        last_st;
	logic                        go;

	function automatic logic [1:0] cyc_cost(input logic [2:0] idx, input logic per,
		input logic slw);
		logic [1:0] c;
		c = IST_ST_MEM;
		if (idx == IST_CYC_INTOP)
			c = IST_ST_INTOP; // RULE_02
		else if ((idx == IST_CYC_BYTE || idx == IST_CYC_WORD) && per)
			c = slw ? IST_ST_PERI_SLOW : IST_ST_PERI_FAST; // RULE_03
		return c;
	endfunction

	function automatic logic [2:0] first_nz(input ist_cnt_t c, input logic [2:0] from);
		logic [2:0] r;
		r = IST_CYC_NONE;
		for (int x = 5; x >= 0; x--)
		begin
			if (3'(x) >= from && c[x] != IST_CNT_ZERO)
				r = 3'(x);
		end
		return r;
	endfunction

	function automatic logic [IST_TOT_W-1:0] sum_states(input ist_cnt_t c, input logic per,
		input logic slw);
		logic [IST_TOT_W-1:0] s;
		s = '0;
		for (int x = 0; x < 6; x++)
			s = IST_TOT_W'(s + c[x] * cyc_cost(3'(x), per, slw)); // RULE_01
		return s;
	endfunction

	// Class decode to cycle counts
	always_comb
	begin
		req_cnt = '0;
		case (REQ.cls)
			IST_CLS_REG_ALU:
				req_cnt[IST_CYC_FETCH] = IST_CNT_ONE; // RULE_06
			IST_CLS_BRANCH8:
				req_cnt[IST_CYC_FETCH] = IST_CNT_TWO; // RULE_06
			IST_CLS_BIT_SET, IST_CLS_BIT_CLR:
			begin
				req_cnt[IST_CYC_FETCH] = IST_CNT_TWO; // RULE_04
				req_cnt[IST_CYC_BYTE]  = IST_CNT_TWO; // RULE_06
			end
			IST_CLS_BIT_AND:
			begin
				req_cnt[IST_CYC_FETCH] = IST_CNT_TWO; // RULE_06
				req_cnt[IST_CYC_BYTE]  = IST_CNT_ONE;
			end
			IST_CLS_SUBR_IND:
			begin
				req_cnt[IST_CYC_FETCH] = IST_CNT_TWO; // RULE_05
				req_cnt[IST_CYC_BRADR] = IST_CNT_ONE;
				req_cnt[IST_CYC_STACK] = IST_CNT_ONE;
			end
			default:
				req_cnt = REQ.cnt;
		endcase
	end

	// Cycle walk helpers
	always_comb
	begin
		cnt_dec = cnt_r;
		if (idx_r < IST_CYC_NONE)
			cnt_dec[idx_r] = cnt_r[idx_r] - IST_CNT_ONE;
		idx_nxt = first_nz(cnt_dec, idx_r);
		idx_first = first_nz(req_cnt, IST_CYC_FETCH);
	end

	assign last_st = (state_r == IST_S_RUN) && (st_r == 2'h1);
	assign go      = START && (state_r != IST_S_RUN);

	// Control state
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			state_r <= IST_S_IDLE;
			idx_r   <= IST_CYC_NONE;
			st_r    <= 2'h0;
			cnt_r   <= '0;
		end
		else if (go)
		begin
			cnt_r   <= req_cnt;
			idx_r   <= idx_first;
			st_r    <= cyc_cost(idx_first, REQ.periph, REQ.slow);
			state_r <= (idx_first == IST_CYC_NONE) ? IST_S_DONE : IST_S_RUN;
		end
		else if (state_r == IST_S_RUN)
		begin
			if (last_st)
			begin
				cnt_r <= cnt_dec;
				idx_r <= idx_nxt;
				st_r  <= cyc_cost(idx_nxt, periph_r, slow_r); // RULE_01
				if (idx_nxt == IST_CYC_NONE)
					state_r <= IST_S_DONE;
			end
			else
				st_r <= st_r - 2'h1;
		end
		else
			state_r <= IST_S_IDLE;
	end

	// Latched access target and expected total
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			periph_r <= 1'b0;
			slow_r   <= 1'b0;
			exp_r    <= '0;
		end
		else if (go)
		begin
			periph_r <= REQ.periph;
			slow_r   <= REQ.slow;
			exp_r    <= sum_states(req_cnt, REQ.periph, REQ.slow); // RULE_01
		end
	end

	// Outputs
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			BUSY         <= 1'b0;
			DONE         <= 1'b0;
			CYC_STROBE   <= 1'b0;
			CYC_TYPE     <= IST_CYC_NONE;
			TOTAL_STATES <= '0;
		end
		else
		begin
			BUSY       <= go ? (idx_first != IST_CYC_NONE)
				: (state_r == IST_S_RUN) && !(last_st && idx_nxt == IST_CYC_NONE);
			DONE       <= go ? (idx_first == IST_CYC_NONE)
				: (last_st && idx_nxt == IST_CYC_NONE);
			CYC_STROBE <= go ? (idx_first != IST_CYC_NONE)
				: (last_st && idx_nxt != IST_CYC_NONE);
			if (go)
				CYC_TYPE <= idx_first;
			else if (last_st)
				CYC_TYPE <= idx_nxt;
			if (go)
				TOTAL_STATES <= '0;
			else if (state_r == IST_S_RUN)
				TOTAL_STATES <= TOTAL_STATES + 9'h001; // RULE_01
		end
	end

	// Length of the current cycle in states
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			len_r <= 2'h0;
		else if (go || last_st)
			len_r <= 2'h1;
		else if (state_r == IST_S_RUN)
			len_r <= len_r + 2'h1;
	end

	a_total_matches: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_01
		DONE |-> TOTAL_STATES == exp_r)
		else $error("total states differ from summed cost");

	a_mem_cycle_len: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_02
		last_st && idx_r != IST_CYC_INTOP
		&& !(periph_r && (idx_r == IST_CYC_BYTE || idx_r == IST_CYC_WORD))
		|-> len_r == 2'h2)
		else $error("on-chip memory cycle not 2 states");

	a_intop_len: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_02
		last_st && idx_r == IST_CYC_INTOP |-> len_r == 2'h1)
		else $error("internal operation not 1 state");

	a_periph_len: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_03
		last_st && periph_r && (idx_r == IST_CYC_BYTE || idx_r == IST_CYC_WORD)
		|-> len_r == (slow_r ? 2'h3 : 2'h2))
		else $error("peripheral access length wrong");

	a_bit_set_eight: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_04
		go && REQ.cls == IST_CLS_BIT_SET && !REQ.periph
		|=> exp_r == 9'h008 && BUSY && CYC_TYPE == IST_CYC_FETCH ##8 DONE)
		else $error("bit set not 8 states");

	a_subr_eight: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_05
		go && REQ.cls == IST_CLS_SUBR_IND
		|=> exp_r == 9'h008 ##4 CYC_TYPE == IST_CYC_BRADR ##2 CYC_TYPE == IST_CYC_STACK)
		else $error("subroutine jump sequence wrong");

	a_reg_alu_one: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_06
		go && REQ.cls == IST_CLS_REG_ALU |=> exp_r == 9'h002 ##2 DONE)
		else $error("register op not one fetch");

	a_branch_two: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_06
		go && REQ.cls == IST_CLS_BRANCH8 |=> exp_r == 9'h004 ##4 DONE)
		else $error("branch not two fetches");

	a_bit_and_len: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_06
		go && REQ.cls == IST_CLS_BIT_AND && !REQ.periph |=> exp_r == 9'h006)
		else $error("bit and not two fetches plus one byte");

endmodule

// ### tb/ist_mem_model.sv
`timescale 1ns/1ps
module ist_mem_model
(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         clr,
	input  wire logic         strobe,
	input  wire logic [2:0]   cyc_type,
	output ist_pkg::ist_cnt_t seen,
	output logic              order_err
);
	import ist_pkg::*;
	logic [2:0] last_r;
	// Cycles served per type
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			seen <= '0;
		else if (clr)
			seen <= '0;
		else if (strobe && cyc_type < IST_CYC_NONE)
			seen[cyc_type] <= seen[cyc_type] + IST_CNT_ONE;
	end
	// Types never go backwards
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			last_r    <= IST_CYC_FETCH;
			order_err <= 1'b0;
		end
		else if (clr)
		begin
			last_r    <= IST_CYC_FETCH;
			order_err <= 1'b0;
		end
		else if (strobe)
		begin
			last_r    <= cyc_type;
			order_err <= order_err | (cyc_type < last_r);
		end
	end
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import ist_pkg::*;
	logic clk = 0, rst_n = 0, start = 0, clr = 0, busy, done, strobe, oerr;
	logic [2:0] cyc_type;
	logic [8:0] total;
	ist_req_s req = '0;
	ist_cnt_t seen;
	int num_errors = 0, checks_done = 0;
	typedef struct packed {
		ist_req_s   req;
		logic [8:0] states;
	} ist_row_s;
	ist_row_s rows [12] = '{
		'{'{IST_CLS_REG_ALU, 24'h000001, 1'b0, 1'b0}, 9'h002},
		'{'{IST_CLS_BRANCH8, 24'h000002, 1'b0, 1'b0}, 9'h004},
		'{'{IST_CLS_BIT_SET, 24'h002002, 1'b0, 1'b0}, 9'h008},
		'{'{IST_CLS_BIT_CLR, 24'h002002, 1'b0, 1'b0}, 9'h008},
		'{'{IST_CLS_BIT_AND, 24'h001002, 1'b0, 1'b0}, 9'h006},
		'{'{IST_CLS_SUBR_IND, 24'h000112, 1'b0, 1'b0}, 9'h008},
		'{'{IST_CLS_BIT_SET, 24'h002002, 1'b1, 1'b0}, 9'h008},
		'{'{IST_CLS_BIT_SET, 24'h002002, 1'b1, 1'b1}, 9'h00A},
		'{'{IST_CLS_BIT_AND, 24'h001002, 1'b1, 1'b1}, 9'h007},
		'{'{IST_CLS_CUSTOM, 24'h111111, 1'b0, 1'b0}, 9'h00B},
		'{'{IST_CLS_CUSTOM, 24'h111111, 1'b1, 1'b1}, 9'h00D},
		'{'{IST_CLS_CUSTOM, 24'h000000, 1'b0, 1'b0}, 9'h000}};
	always #2.5 clk = ~clk;
	ist_timing i_ist_timing (.CLK(clk), .RST_N(rst_n), .START(start), .REQ(req),
		.BUSY(busy), .DONE(done), .CYC_STROBE(strobe), .CYC_TYPE(cyc_type),
		.TOTAL_STATES(total));
	ist_mem_model i_ist_mem_model (.clk(clk), .rst_n(rst_n), .clr(clr), .strobe(strobe),
		.cyc_type(cyc_type), .seen(seen), .order_err(oerr));
	task automatic check_val(input logic [8:0] got, input logic [8:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s got %0d want %0d", $time, what, got, exp);
		end
	endtask
	task automatic check_cnt(input ist_cnt_t got, input ist_cnt_t exp);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t: cycle counts %h want %h", $time, got, exp);
		end
	endtask
	task automatic check_idle();
		check_val({busy, done, strobe}, 9'h000, "idle flags");
		check_val(total, 9'h000, "reset total");
		check_val(9'(cyc_type), 9'(IST_CYC_NONE), "reset type");
	endtask
	task automatic run(input ist_row_s w, input int poke);
		int n, b;
		ist_req_s r;
		logic [8:0] e;
		r = w.req;
		e = w.states;
		b = 0;
		start = 1'b1;
		req = r;
		clr = 1'b1;
		@(negedge clk);
		clr = 1'b0;
		start = 1'b0;
		n = 1;
		while (done !== 1'b1 && n < 300)
		begin
			b += int'(busy === 1'b1);
			start = (n == poke);
			req.cls = (n == poke) ? IST_CLS_REG_ALU : r.cls;
			@(negedge clk);
			n++;
		end
		check_val(9'(done), 9'h001, "done seen");
		if (done !== 1'b1)
			tally_and_finish();
		check_val(9'(n), e + 9'h001, "done cycle");
		check_val(9'(b), e, "busy cycles");
		check_val(total, e, "total states");
		check_cnt(seen, r.cnt);
		check_val(9'(oerr), 9'h000, "cycle order");
		$display("Test class %0d done, %0d states", r.cls, e);
	endtask
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(negedge clk);
		check_idle();
		$display("Test reset done");
		rst_n = 1'b1;
		for (int i = 0; i < 12; i++)
			run(rows[i], 0);
		@(negedge clk);
		run(rows[5], 3);
		run(rows[2], 0);
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		repeat (3) @(negedge clk);
		rst_n = 1'b0;
		#1;
		check_idle();
		@(negedge clk);
		rst_n = 1'b1;
		$display("Test mid-run reset done");
		run(rows[8], 0);
		tally_and_finish();
	end
endmodule
